// ### lbp_breath_regs.vh
`ifndef LBP_BREATH_REGS_VH
`define LBP_BREATH_REGS_VH

// Register byte addresses
`define LBP_ADDR_WB_RED      8'h90
`define LBP_ADDR_WB_GREEN    8'h91
`define LBP_ADDR_WB_BLUE     8'h92
`define LBP_ADDR_PAT_CFG     8'hA0
`define LBP_ADDR_PAT_RUN     8'hA1
`define LBP_ADDR_TIMER_RO    8'hA2
`define LBP_ADDR_TIMER_FO    8'hA3
`define LBP_ADDR_LOOP_HI     8'hA4
`define LBP_ADDR_LOOP_LO     8'hA5
`define LBP_ADDR_MAX_LEVEL   8'hA6
`define LBP_ADDR_MIN_LEVEL   8'hA7
`define LBP_ADDR_GCOL_RED    8'hA8
`define LBP_ADDR_GCOL_GREEN  8'hA9

// Reset values
`define LBP_RST_WB           8'hFF
`define LBP_RST_ZERO         8'h00
`define LBP_RST_NIBBLE       4'h0
`define LBP_RST_LOOP_HI      8'h00

// pattern_config fields
`define LBP_CFG_ENABLE_BIT   0
`define LBP_CFG_MODE_BIT     1
`define LBP_CFG_RAMP_BIT     2
`define LBP_CFG_SWITCH_BIT   3
`define LBP_CFG_WIDTH        4

// pattern_run_status fields
`define LBP_RUN_GO_BIT       0
`define LBP_RUN_STATE_BIT    1
`define LBP_RUN_END_BIT      2

// Timer and loop control field positions
`define LBP_HI_NIB           7:4
`define LBP_LO_NIB           3:0
`define LBP_LOOP_END_FLD     7:6
`define LBP_LOOP_START_FLD   5:4
`define LBP_LOOP_START_RISE  2'h0
`define LBP_LOOP_START_ON    2'h1
`define LBP_LOOP_START_FALL  2'h2
`define LBP_LOOP_END_OFF     2'h0

// Time base: one tick per millisecond
`define LBP_CLK_NS           40
`define LBP_TICK_NS          1000000

// Phase durations in ms per 4-bit code
`define LBP_T_HOLD_C0        14'd40
`define LBP_T_C0             14'd0
`define LBP_T_C1             14'd130
`define LBP_T_C2             14'd260
`define LBP_T_C3             14'd380
`define LBP_T_C4             14'd510
`define LBP_T_C5             14'd770
`define LBP_T_C6             14'd1040
`define LBP_T_C7             14'd1600
`define LBP_T_C8             14'd2100
`define LBP_T_C9             14'd2600
`define LBP_T_C10            14'd3100
`define LBP_T_C11            14'd4200
`define LBP_T_C12            14'd5200
`define LBP_T_C13            14'd6200
`define LBP_T_C14            14'd7300
`define LBP_T_C15            14'd8300

`endif

// ### lbp_phase_timer.v
`include "lbp_breath_regs.vh"

module lbp_phase_timer (
    mclk,
    rst_b,
    restart,
    msTick,
    durCode,
    holdPhase,
    durMs,
    phaseDone
);
    input wire mclk;
    input wire rst_b;
    input wire restart;
    input wire msTick;
    input wire [3:0] durCode;
    input wire holdPhase;
    output reg [13:0] durMs;
    output wire phaseDone;

    reg [13:0] elapsed_r;

    ////////////////////////////////////////////////////////////////////////
    // Code to milliseconds; hold phases never run shorter than 40 ms
    always @* begin
        case (durCode)
            4'h0: durMs = holdPhase ? `LBP_T_HOLD_C0 : `LBP_T_C0;
            4'h1: durMs = `LBP_T_C1;
            4'h2: durMs = `LBP_T_C2;
            4'h3: durMs = `LBP_T_C3;
            4'h4: durMs = `LBP_T_C4;
            4'h5: durMs = `LBP_T_C5;
            4'h6: durMs = `LBP_T_C6;
            4'h7: durMs = `LBP_T_C7;
            4'h8: durMs = `LBP_T_C8;
            4'h9: durMs = `LBP_T_C9;
            4'hA: durMs = `LBP_T_C10;
            4'hB: durMs = `LBP_T_C11;
            4'hC: durMs = `LBP_T_C12;
            4'hD: durMs = `LBP_T_C13;
            4'hE: durMs = `LBP_T_C14;
            default: durMs = `LBP_T_C15;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Elapsed millisecond count, restarted at each phase entry
    always @(posedge mclk) begin
        if (!rst_b || restart) begin
            elapsed_r <= 14'h0000;
        end else if (msTick && !phaseDone) begin
            elapsed_r <= elapsed_r + 14'h0001;
        end
    end

    // A zero-length phase is done right away
    assign phaseDone = (elapsed_r >= durMs);

endmodule // lbp_phase_timer

// ### lbp_breath_ctrl.v
// Overview of operation
// - Manual mode: switch bit turns LEDs on/off
// - Ramp enable bit gates brightness ramping
// - Mode bit: 0 manual, 1 auto breathing
// - Controller enable bit gates auto breathing
// - Writing run bit 1 while it holds 0 starts sequence
// - Status bit shows sequence running
// - Loop end flag set, cleared on read
// - Timer 0: rise and hold-on durations
// - Timer 1: fall and hold-off durations
// - End-point field chooses final OFF/ON state
// - Loop start field picks first phase
// - Twelve-bit repeat count across two registers
// - Zero repeat count loops forever
// - Maximum brightness register, resets to zero
// - Minimum brightness register, resets to zero
// - White-balance scale registers reset to 0xFF
// - Group colour red/green registers reset zero
// - Enabled triplets follow breathing when enabled
// - Shared colour disable selects colour source
`include "lbp_breath_regs.vh"

module lbp_breath_ctrl #(
    parameter TICK_CYCLES = `LBP_TICK_NS / `LBP_CLK_NS
) (
    mclk,
    rst_b,
    regAddr,
    regWrData,
    regWrEn,
    regRdEn,
    regRdData,
    groupTripletEnable,
    sharedColourDisable,
    breathLevel,
    patternRunning,
    groupBreathEn,
    useGroupColour,
    groupColourRed,
    groupColourGreen,
    wbRed,
    wbGreen,
    wbBlue
);
    input wire mclk;
    input wire rst_b;
    input wire [7:0] regAddr;
    input wire [7:0] regWrData;
    input wire regWrEn;
    input wire regRdEn;
    output reg [7:0] regRdData;
    input wire [11:0] groupTripletEnable;
    input wire sharedColourDisable;
    output reg [7:0] breathLevel;
    output wire patternRunning;
    output wire [11:0] groupBreathEn;
    output wire useGroupColour;
    output wire [7:0] groupColourRed;
    output wire [7:0] groupColourGreen;
    output wire [7:0] wbRed;
    output wire [7:0] wbGreen;
    output wire [7:0] wbBlue;

    // One-hot sequencer states
    localparam [4:0] ST_IDLE = 5'h01;
    localparam [4:0] ST_RISE = 5'h02;
    localparam [4:0] ST_ON = 5'h04;
    localparam [4:0] ST_FALL = 5'h08;
    localparam [4:0] ST_OFF = 5'h10;

    localparam [31:0] TICK_LAST = TICK_CYCLES - 1;

    reg [7:0] wbRed_r, wbGreen_r, wbBlue_r;
    reg [`LBP_CFG_WIDTH-1:0] cfg_r;
    reg runBit_r;
    reg endFlag_r;
    reg [7:0] timerRiseOn_r, timerFallOff_r, loopHi_r, loopLo_r;
    reg [7:0] maxLevel_r, minLevel_r, gcolRed_r, gcolGreen_r;
    reg [4:0] state_r, state_nxt;
    reg [11:0] loopCnt_r;
    reg [13:0] acc_r;
    reg [31:0] tickCnt_r;
    reg [3:0] durCode;
    reg [4:0] startState;
    reg [4:0] lastState;
    reg [7:0] endLevel;

    wire wrHit;
    wire autoAllowed;
    wire startReq;
    wire msTick;
    wire phaseDone;
    wire [13:0] durMs;
    wire [11:0] repeatCount;
    wire [7:0] span;
    wire [13:0] accSum;
    wire loopWrap;
    wire finishNow;

    assign wrHit = regWrEn;
    assign autoAllowed = cfg_r[`LBP_CFG_MODE_BIT] && cfg_r[`LBP_CFG_ENABLE_BIT];

    ////////////////////////////////////////////////////////////////////////
    // Register writes
    always @(posedge mclk) begin
        if (!rst_b) begin
            wbRed_r <= `LBP_RST_WB;
            wbGreen_r <= `LBP_RST_WB;
            wbBlue_r <= `LBP_RST_WB;
            cfg_r <= `LBP_RST_NIBBLE;
            runBit_r <= 1'b0;
            timerRiseOn_r <= `LBP_RST_ZERO;
            timerFallOff_r <= `LBP_RST_ZERO;
            loopHi_r <= `LBP_RST_LOOP_HI;
            loopLo_r <= `LBP_RST_ZERO;
            maxLevel_r <= `LBP_RST_ZERO;
            minLevel_r <= `LBP_RST_ZERO;
            gcolRed_r <= `LBP_RST_ZERO;
            gcolGreen_r <= `LBP_RST_ZERO;
        end else if (wrHit) begin
            case (regAddr)
                `LBP_ADDR_WB_RED: wbRed_r <= regWrData;
                `LBP_ADDR_WB_GREEN: wbGreen_r <= regWrData;
                `LBP_ADDR_WB_BLUE: wbBlue_r <= regWrData;
                `LBP_ADDR_PAT_CFG: cfg_r <= regWrData[`LBP_CFG_WIDTH-1:0];
                `LBP_ADDR_PAT_RUN: runBit_r <= regWrData[`LBP_RUN_GO_BIT];
                `LBP_ADDR_TIMER_RO: timerRiseOn_r <= regWrData;
                `LBP_ADDR_TIMER_FO: timerFallOff_r <= regWrData;
                `LBP_ADDR_LOOP_HI: loopHi_r <= regWrData;
                `LBP_ADDR_LOOP_LO: loopLo_r <= regWrData;
                `LBP_ADDR_MAX_LEVEL: maxLevel_r <= regWrData;
                `LBP_ADDR_MIN_LEVEL: minLevel_r <= regWrData;
                `LBP_ADDR_GCOL_RED: gcolRed_r <= regWrData;
                `LBP_ADDR_GCOL_GREEN: gcolGreen_r <= regWrData;
                default: ;
            endcase
        end
    end

    assign startReq = wrHit && (regAddr == `LBP_ADDR_PAT_RUN)
                      && regWrData[`LBP_RUN_GO_BIT] && !runBit_r && autoAllowed;

    ////////////////////////////////////////////////////////////////////////
    // Register reads; data registered, unmapped addresses read zero
    always @(posedge mclk) begin
        if (!rst_b) begin
            regRdData <= `LBP_RST_ZERO;
        end else if (regRdEn) begin
            case (regAddr)
                `LBP_ADDR_WB_RED: regRdData <= wbRed_r;
                `LBP_ADDR_WB_GREEN: regRdData <= wbGreen_r;
                `LBP_ADDR_WB_BLUE: regRdData <= wbBlue_r;
                `LBP_ADDR_PAT_CFG: regRdData <= {4'h0, cfg_r};
                `LBP_ADDR_PAT_RUN: regRdData <= {5'h00, endFlag_r, patternRunning, runBit_r};
                `LBP_ADDR_TIMER_RO: regRdData <= timerRiseOn_r;
                `LBP_ADDR_TIMER_FO: regRdData <= timerFallOff_r;
                `LBP_ADDR_LOOP_HI: regRdData <= loopHi_r;
                `LBP_ADDR_LOOP_LO: regRdData <= loopLo_r;
                `LBP_ADDR_MAX_LEVEL: regRdData <= maxLevel_r;
                `LBP_ADDR_MIN_LEVEL: regRdData <= minLevel_r;
                `LBP_ADDR_GCOL_RED: regRdData <= gcolRed_r;
                `LBP_ADDR_GCOL_GREEN: regRdData <= gcolGreen_r;
                default: regRdData <= `LBP_RST_ZERO;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Millisecond enable pulse from the master clock
    always @(posedge mclk) begin
        if (!rst_b || state_r == ST_IDLE) begin
            tickCnt_r <= 32'h00000000;
        end else if (tickCnt_r == TICK_LAST) begin
            tickCnt_r <= 32'h00000000;
        end else begin
            tickCnt_r <= tickCnt_r + 32'h00000001;
        end
    end
    assign msTick = (tickCnt_r == TICK_LAST);

    ////////////////////////////////////////////////////////////////////////
    // Duration code of the current phase
    always @* begin
        case (state_r)
            ST_RISE: durCode = timerRiseOn_r[`LBP_HI_NIB];
            ST_ON: durCode = timerRiseOn_r[`LBP_LO_NIB];
            ST_FALL: durCode = timerFallOff_r[`LBP_HI_NIB];
            ST_OFF: durCode = timerFallOff_r[`LBP_LO_NIB];
            default: durCode = 4'h0;
        endcase
    end

    lbp_phase_timer u_timer (
        .mclk(mclk),
        .rst_b(rst_b),
        .restart(state_nxt != state_r),
        .msTick(msTick),
        .durCode(durCode),
        .holdPhase(state_r == ST_ON || state_r == ST_OFF),
        .durMs(durMs),
        .phaseDone(phaseDone)
    );

    ////////////////////////////////////////////////////////////////////////
    // Loop start phase and the phase that closes each loop
    always @* begin
        case (loopHi_r[`LBP_LOOP_START_FLD])
            `LBP_LOOP_START_RISE: begin
                startState = ST_RISE;
                lastState = ST_OFF;
            end
            `LBP_LOOP_START_ON: begin
                startState = ST_ON;
                lastState = ST_RISE;
            end
            `LBP_LOOP_START_FALL: begin
                startState = ST_FALL;
                lastState = ST_ON;
            end
            default: begin
                startState = ST_OFF;
                lastState = ST_FALL;
            end
        endcase
    end

    assign repeatCount = {loopHi_r[`LBP_LO_NIB], loopLo_r};
    assign loopWrap = (state_r == lastState) && phaseDone;
    assign finishNow = loopWrap && (repeatCount != 12'h000)
                       && (loopCnt_r + 12'h001 == repeatCount);

    always @* begin
        if (loopHi_r[`LBP_LOOP_END_FLD] == `LBP_LOOP_END_OFF) begin
            endLevel = minLevel_r;
        end else begin
            endLevel = maxLevel_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Phase sequencer; dropping mode or enable stops it at once
    always @* begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: begin
                if (startReq) begin
                    state_nxt = startState;
                end
            end
            ST_RISE, ST_ON, ST_FALL, ST_OFF: begin
                if (!autoAllowed || finishNow) begin
                    state_nxt = ST_IDLE;
                end else if (phaseDone) begin
                    state_nxt = (state_r == ST_OFF) ? ST_RISE : {state_r[3:0], 1'b0};
                end
            end
            default: state_nxt = ST_IDLE;
        endcase
    end

    always @(posedge mclk) begin
        if (!rst_b) begin
            state_r <= ST_IDLE;
            loopCnt_r <= 12'h000;
        end else begin
            state_r <= state_nxt;
            if (state_r == ST_IDLE) begin
                loopCnt_r <= 12'h000;
            end else if (loopWrap) begin
                loopCnt_r <= loopCnt_r + 12'h001;
            end
        end
    end

    assign patternRunning = (state_r != ST_IDLE);

    ////////////////////////////////////////////////////////////////////////
    // Loop end flag: a set in the same cycle as the read wins
    always @(posedge mclk) begin
        if (!rst_b) begin
            endFlag_r <= 1'b0;
        end else if (finishNow) begin
            endFlag_r <= 1'b1;
        end else if (regRdEn && regAddr == `LBP_ADDR_PAT_RUN) begin
            endFlag_r <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Brightness; the ramp steps one level at most per ms, though the span (up to 255)
    // can exceed the shortest nonzero ramp duration (130 ms); no divider is used
    assign span = (maxLevel_r > minLevel_r) ? (maxLevel_r - minLevel_r) : 8'h00;
    assign accSum = acc_r + {6'h00, span};

    always @(posedge mclk) begin
        if (!rst_b) begin
            breathLevel <= `LBP_RST_ZERO;
            acc_r <= 14'h0000;
        end else if (state_r == ST_IDLE) begin
            acc_r <= 14'h0000;
            if (!cfg_r[`LBP_CFG_MODE_BIT]) begin
                breathLevel <= cfg_r[`LBP_CFG_SWITCH_BIT] ? maxLevel_r : `LBP_RST_ZERO;
            end else if (startReq) begin
                // ramps start from the far level
                if (startState == ST_RISE && cfg_r[`LBP_CFG_RAMP_BIT]) begin
                    breathLevel <= minLevel_r;
                end else if (startState == ST_FALL && cfg_r[`LBP_CFG_RAMP_BIT]) begin
                    breathLevel <= maxLevel_r;
                end else if (startState == ST_OFF || startState == ST_FALL) begin
                    breathLevel <= minLevel_r;
                end else begin
                    breathLevel <= maxLevel_r;
                end
            end
        end else if (finishNow) begin
            breathLevel <= endLevel;
        end else if (state_nxt != state_r) begin
            acc_r <= 14'h0000;
            // entry levels with and without ramping
            case (state_nxt)
                ST_RISE: breathLevel <= cfg_r[`LBP_CFG_RAMP_BIT] ? minLevel_r : maxLevel_r;
                ST_ON: breathLevel <= maxLevel_r;
                ST_FALL: breathLevel <= cfg_r[`LBP_CFG_RAMP_BIT] ? maxLevel_r : minLevel_r;
                default: breathLevel <= minLevel_r;
            endcase
        end else if (msTick && cfg_r[`LBP_CFG_RAMP_BIT] && !phaseDone) begin
            if (accSum >= durMs) begin
                acc_r <= accSum - durMs;
                if (state_r == ST_RISE) begin
                    breathLevel <= breathLevel + 8'h01;
                end else if (state_r == ST_FALL) begin
                    breathLevel <= breathLevel - 8'h01;
                end
            end else begin
                acc_r <= accSum;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Triplets under breathing control while the controller is enabled
    genvar gi;
    generate
        for (gi = 0; gi < 12; gi = gi + 1) begin : g_triplet
            assign groupBreathEn[gi] = groupTripletEnable[gi] && cfg_r[`LBP_CFG_ENABLE_BIT];
        end
    endgenerate

    assign useGroupColour = !sharedColourDisable;
    assign groupColourRed = gcolRed_r;
    assign groupColourGreen = gcolGreen_r;
    assign wbRed = wbRed_r;
    assign wbGreen = wbGreen_r;
    assign wbBlue = wbBlue_r;

endmodule // lbp_breath_ctrl

// ### lbp_breath_ctrl_asserts.sv
module lbp_breath_ctrl_asserts #(
    parameter int TICK_CYCLES = 25000
) (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWrEn,
    input wire logic regRdEn,
    input wire logic [7:0] regRdData,
    input wire logic [11:0] groupTripletEnable,
    input wire logic sharedColourDisable,
    input wire logic [7:0] breathLevel,
    input wire logic patternRunning,
    input wire logic [11:0] groupBreathEn,
    input wire logic useGroupColour,
    input wire logic [7:0] groupColourRed,
    input wire logic [7:0] groupColourGreen,
    input wire logic [7:0] wbRed,
    input wire logic [7:0] wbGreen,
    input wire logic [7:0] wbBlue
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);

    logic startSeen_r;

    // Remember a run request to trace each start
    always @(posedge mclk) begin
        startSeen_r <= regWrEn && regAddr == 8'hA1 && regWrData[0];
    end

    ////////////////////////////////////////////////////////////////
    // Config write to manual-off, not overwritten in the next cycle
    sequence seqCfgOff;
        regWrEn && regAddr == 8'hA0 && regWrData[3:1] == 3'h0 ##1 !(regWrEn && regAddr == 8'hA0);
    endsequence
    // Controller enable set while the triplet inputs stay put
    sequence seqEnableSet;
        regWrEn && regAddr == 8'hA0 && regWrData[0] ##1 $stable(groupTripletEnable);
    endsequence

    a_reset_values: assert property ($rose(rst_b) |-> wbRed == 8'hFF && wbGreen == 8'hFF
        && wbBlue == 8'hFF && groupColourRed == 8'h00 && breathLevel == 8'h00 && !patternRunning)
        else $error("reset values wrong");
    a_wb_red_write: assert property (regWrEn && regAddr == 8'h90 |=> wbRed == $past(regWrData))
        else $error("red balance write lost");
    a_gcol_green_write: assert property (regWrEn && regAddr == 8'hA9
        |=> groupColourGreen == $past(regWrData)) else $error("group green write lost");
    a_colour_select: assert property (useGroupColour == !sharedColourDisable)
        else $error("colour source select wrong");
    a_triplet_subset: assert property ((groupBreathEn & ~groupTripletEnable) == 12'h000)
        else $error("breath enable outside triplet set");
    a_enable_follow: assert property (seqEnableSet |-> groupBreathEn == groupTripletEnable)
        else $error("triplets not following enable");
    a_unmapped_read: assert property (regRdEn && !(regAddr inside {[8'h90:8'h92], [8'hA0:8'hA9]})
        |=> regRdData == 8'h00) else $error("unmapped read not zero");
    a_blue_read: assert property (regRdEn && regAddr == 8'h92 && !regWrEn
        |=> regRdData == wbBlue) else $error("blue balance read wrong");
    a_status_reserved: assert property (regRdEn && regAddr inside {8'hA0, 8'hA1}
        |=> regRdData[7:4] == 4'h0) else $error("reserved bits not zero");
    a_manual_off: assert property (seqCfgOff |-> ##2 breathLevel == 8'h00 && !patternRunning)
        else $error("manual off not honoured");
    a_start_cause: assert property ($rose(patternRunning) |-> startSeen_r)
        else $error("run started without request");
endmodule // lbp_breath_ctrl_asserts

bind lbp_breath_ctrl lbp_breath_ctrl_asserts #(.TICK_CYCLES(TICK_CYCLES)) u_chk (
    .mclk(mclk), .rst_b(rst_b), .regAddr(regAddr), .regWrData(regWrData), .regWrEn(regWrEn),
    .regRdEn(regRdEn), .regRdData(regRdData), .groupTripletEnable(groupTripletEnable),
    .sharedColourDisable(sharedColourDisable), .breathLevel(breathLevel),
    .patternRunning(patternRunning), .groupBreathEn(groupBreathEn),
    .useGroupColour(useGroupColour), .groupColourRed(groupColourRed),
    .groupColourGreen(groupColourGreen), .wbRed(wbRed), .wbGreen(wbGreen), .wbBlue(wbBlue));

// ### lbp_host_model.sv
module lbp_host_model (
    input wire logic mclk,
    output logic [7:0] regAddr,
    output logic [7:0] regWrData,
    output logic regWrEn,
    output logic regRdEn,
    input wire logic [7:0] regRdData
);
    timeunit 1ns;
    timeprecision 1ns;

    // Quiet bus at time zero
    initial begin
        regAddr = 8'h00;
        regWrData = 8'h00;
        regWrEn = 1'b0;
        regRdEn = 1'b0;
    end

    // One write strobe; address and data are inverted afterwards so no stale value lingers
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge mclk);
        regAddr = a;
        regWrData = d;
        regWrEn = 1'b1;
        @(negedge mclk);
        regWrEn = 1'b0;
        regAddr = ~a;
        regWrData = ~d;
    endtask

    // One read strobe; data is taken after the edge that accepted it
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge mclk);
        regAddr = a;
        regRdEn = 1'b1;
        @(negedge mclk);
        regRdEn = 1'b0;
        regAddr = ~a;
        d = regRdData;
    endtask

    task automatic restart;
        wr(8'hA1, 8'h00);
        wr(8'hA1, 8'h01);
    endtask

    task automatic stop_forever;
        wr(8'hA0, 8'h01);
        wr(8'hA0, 8'h00);
    endtask
endmodule // lbp_host_model

// ### tb.sv
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int TICKS = 4;
    localparam int LOOP = 2 * (40 * TICKS + 1) + 2;
    logic mclk;
    logic rst_b;
    logic [11:0] groupTripletEnable;
    logic sharedColourDisable;
    wire [7:0] regAddr, regWrData, regRdData, breathLevel;
    wire regWrEn, regRdEn, patternRunning, useGroupColour;
    wire [11:0] groupBreathEn;
    wire [7:0] groupColourRed, groupColourGreen, wbRed, wbGreen, wbBlue;
    int n_mismatch = 0, tests_run = 0, cnt;
    logic [7:0] rdVal;

    lbp_breath_ctrl #(.TICK_CYCLES(TICKS)) uut (.mclk(mclk), .rst_b(rst_b), .regAddr(regAddr),
        .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData),
        .groupTripletEnable(groupTripletEnable), .sharedColourDisable(sharedColourDisable),
        .breathLevel(breathLevel), .patternRunning(patternRunning), .groupBreathEn(groupBreathEn),
        .useGroupColour(useGroupColour), .groupColourRed(groupColourRed),
        .groupColourGreen(groupColourGreen), .wbRed(wbRed), .wbGreen(wbGreen), .wbBlue(wbBlue));
    lbp_host_model host (.mclk(mclk), .regAddr(regAddr), .regWrData(regWrData),
        .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData));

    ////////////////////////////////////////////////////////////////
    task automatic complete_run;
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [11:0] exp, input logic [11:0] got);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
        host.rd(a, rdVal);
        chk($sformatf("register %h", a), {4'h0, exp}, {4'h0, rdVal});
    endtask

    // Bounded wait on the running flag; running out of cycles ends the run
    task automatic wait_run(input logic val, input int lim, output int n);
        n = 0;
        while (patternRunning !== val && n < lim) begin
            @(negedge mclk);
            n++;
        end
        if (patternRunning !== val) begin
            n_mismatch++;
            complete_run;
        end
    endtask

    function automatic logic [7:0] addr_of(input int i);
        return i < 3 ? 8'h90 + 8'(i) : 8'h9D + 8'(i);
    endfunction

    ////////////////////////////////////////////////////////////////
    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end

    // Watchdog against a hung sequence
    initial begin
        repeat (100000) @(posedge mclk);
        n_mismatch++;
        complete_run;
    end

    initial begin
        rst_b = 1'b0;
        groupTripletEnable = 12'hA5A;
        sharedColourDisable = 1'b0;
        repeat (3) @(negedge mclk);
        rst_b = 1'b1;
        // Reset values of the whole table, then an unmapped location
        for (int i = 0; i < 13; i++) begin
            rdchk(addr_of(i), i < 3 ? 8'hFF : 8'h00);
        end
        host.wr(8'h7F, 8'h5A);
        rdchk(8'h7F, 8'h00);
        // Write and read back every plain read-write register
        for (int i = 0; i < 13; i++) begin
            if (i == 3 || i == 4) continue;
            host.wr(addr_of(i), 8'h5A + 8'(i * 7));
            rdchk(addr_of(i), 8'h5A + 8'(i * 7));
        end
        chk("wbGreen", 12'h061, {4'h0, wbGreen});
        chk("groupColourRed", 12'h0A7, {4'h0, groupColourRed});
        host.wr(8'hA0, 8'hF0);
        rdchk(8'hA0, 8'h00);
        host.wr(8'hA1, 8'hF8);
        rdchk(8'hA1, 8'h00);
        host.wr(8'hA6, 8'h80);
        host.wr(8'hA7, 8'h10);
        // Manual switch on and off
        host.wr(8'hA0, 8'h08);
        @(negedge mclk);
        chk("manual on level", 12'h080, {4'h0, breathLevel});
        host.wr(8'hA0, 8'h00);
        @(negedge mclk);
        chk("manual off level", 12'h000, {4'h0, breathLevel});
        // Triplet gating and colour source
        host.wr(8'hA0, 8'h01);
        chk("groupBreathEn on", 12'hA5A, groupBreathEn);
        host.wr(8'hA0, 8'h00);
        chk("groupBreathEn off", 12'h000, groupBreathEn);
        sharedColourDisable = 1'b1;
        @(negedge mclk);
        chk("useGroupColour", 12'h000, {11'h0, useGroupColour});
        sharedColourDisable = 1'b0;
        @(negedge mclk);
        chk("useGroupColour", 12'h001, {11'h0, useGroupColour});
        // One loop, ramp off, shortest codes, ends at the low level
        host.wr(8'hA2, 8'h00);
        host.wr(8'hA3, 8'h00);
        host.wr(8'hA4, 8'h00);
        host.wr(8'hA5, 8'h01);
        host.wr(8'hA0, 8'h03);
        host.wr(8'hA1, 8'h01);
        rdchk(8'hA1, 8'h03);
        chk("hold-on level", 12'h080, {4'h0, breathLevel});
        wait_run(1'b0, 4 * LOOP, cnt);
        chk("end level off", 12'h010, {4'h0, breathLevel});
        rdchk(8'hA1, 8'h05);
        rdchk(8'hA1, 8'h01);
        // A second run request without a zero first must not start
        host.wr(8'hA1, 8'h01);
        @(negedge mclk);
        chk("no restart", 12'h000, {11'h0, patternRunning});
        // Two loops, ending at the high level
        host.wr(8'hA4, 8'h40);
        host.wr(8'hA5, 8'h02);
        host.restart;
        wait_run(1'b0, 4 * LOOP, cnt);
        chk("two loops", 12'h001, {11'h0, cnt > 2 * LOOP - 40 && cnt < 2 * LOOP + 40});
        chk("end level on", 12'h080, {4'h0, breathLevel});
        rdchk(8'hA1, 8'h05);
        // Zero count keeps looping until the host stops it
        host.wr(8'hA4, 8'h00);
        host.wr(8'hA5, 8'h00);
        host.restart;
        repeat (5 * LOOP) @(negedge mclk);
        chk("forever running", 12'h001, {11'h0, patternRunning});
        host.stop_forever;
        chk("stopped", 12'h000, {11'h0, patternRunning});
        chk("stopped level", 12'h000, {4'h0, breathLevel});
        // Every loop start point, ramp off
        for (int lb = 0; lb < 4; lb++) begin
            host.wr(8'hA4, {2'h0, 2'(lb), 4'h0});
            host.wr(8'hA0, 8'h03);
            host.restart;
            repeat (3) @(negedge mclk);
            chk("start point level", lb < 2 ? 12'h080 : 12'h010, {4'h0, breathLevel});
            host.wr(8'hA0, 8'h00);
        end
        // Ramped rise from the low to the high level
        host.wr(8'hA2, 8'h11);
        host.wr(8'hA4, 8'h00);
        host.wr(8'hA0, 8'h07);
        host.restart;
        chk("ramp entry", 12'h010, {4'h0, breathLevel});
        repeat (65 * TICKS) @(negedge mclk);
        chk("mid ramp", 12'h001, {11'h0, breathLevel > 8'h10 && breathLevel < 8'h80});
        repeat (70 * TICKS) @(negedge mclk);
        chk("ramp top", 12'h080, {4'h0, breathLevel});
        host.wr(8'hA0, 8'h00);
        complete_run;
    end
endmodule // tb
